// ==== fie_pkg.sv ====
// fiber interrupt enable/pending block: constants, types and field layout
// assumes an ahb-lite register bus with 32-bit data, one clock, async reset
//
// Summary of operation
// [R1] bit 9 enables far end fault, resets one
// [R2] bit 8 enables tx fifo full, resets one
// [R3] bit 7 enables tx fifo empty, resets one
// [R4] bit 6 enables rx fifo full, resets one
// [R5] bit 5 enables rx fifo empty, resets one
// [R6] bit 4 enables link change, resets one
// [R7] bit 3 enables partner remote fault, resets one
// [R8] bit 2 enables priority resolution fail, resets one
// [R9] bit 1 enables partner next page, resets one
// [R10] bit 0 enables partner base page, resets one
// [R11] pending bits clear when status is read
// [R12] pending resets zero, same bit order
// [R13] tx fifo full sets pending bit 8
// [R14] legacy mac interface only at 100/10 speed
// [R15] software disables gigabit advert with legacy interface
// [R16] serial mac interface unusable in fiber/converter modes
// [R17] enable register at c18h, resets 03ffh
// [R18] irq while pending and enabled; reserved reads zero
package fie_pkg;

    // ------------------------------------------------------------
    // register map (printed offsets are indices; byte = index * 4)
    // ------------------------------------------------------------
    localparam logic [11:0] FIE_ENABLE_IDX = 12'hc18;
    localparam logic [11:0] FIE_PENDING_IDX = 12'hc19;
    localparam logic [11:0] FIE_MODE_IDX = 12'hc1a;
    localparam logic [13:0] FIE_ENABLE_ADDR = {FIE_ENABLE_IDX, 2'h0};
    localparam logic [13:0] FIE_PENDING_ADDR = {FIE_PENDING_IDX, 2'h0};
    localparam logic [13:0] FIE_MODE_ADDR = {FIE_MODE_IDX, 2'h0};

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int FIE_NUM_EVENTS = 10;
    localparam logic [15:0] FIE_ENABLE_RESET = 16'h03ff;
    localparam logic [15:0] FIE_PENDING_RESET = 16'h0000;
    localparam int FIE_BIT_FAR_END = 9;
    localparam int FIE_BIT_TX_FULL = 8;
    localparam int FIE_BIT_TX_EMPTY = 7;
    localparam int FIE_BIT_RX_FULL = 6;
    localparam int FIE_BIT_RX_EMPTY = 5;
    localparam int FIE_BIT_LINK = 4;
    localparam int FIE_BIT_REMOTE = 3;
    localparam int FIE_BIT_PRIORITY = 2;
    localparam int FIE_BIT_NEXT_PAGE = 1;
    localparam int FIE_BIT_BASE_PAGE = 0;

    // mode register: bits [1:0] media mode, bits [3:2] mac interface
    localparam int FIE_MODE_MEDIA_LSB = 0;
    localparam int FIE_MODE_MAC_LSB = 2;
    localparam logic [3:0] FIE_MODE_RESET = 4'h0;

    // ahb-lite encodings
    localparam logic [1:0] FIE_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] FIE_HTRANS_SEQ = 2'h3;
    localparam logic [2:0] FIE_HSIZE_WORD = 3'h2;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FIE_MEDIA_COPPER = 2'h0,
        FIE_MEDIA_FIBER = 2'h1,
        FIE_MEDIA_CONVERTER = 2'h2,
        FIE_MEDIA_BRIDGE = 2'h3
    } fie_media_e;

    typedef enum logic [1:0] {
        FIE_MAC_RGMII = 2'h0,
        FIE_MAC_SGMII = 2'h1,
        FIE_MAC_MII = 2'h2,
        FIE_MAC_NONE = 2'h3
    } fie_mac_e;

    typedef enum logic [1:0] {
        FIE_SPEED_10 = 2'h0,
        FIE_SPEED_100 = 2'h1,
        FIE_SPEED_1000 = 2'h2,
        FIE_SPEED_RSVD = 2'h3
    } fie_speed_e;

    // one pulse per event, bit order matches the enable register
    typedef struct packed {
        logic far_end_fault;
        logic tx_fifo_full;
        logic tx_fifo_empty;
        logic rx_fifo_full;
        logic rx_fifo_empty;
        logic link_change;
        logic partner_remote_fault;
        logic priority_resolution_fail;
        logic partner_next_page;
        logic partner_base_page;
    } fie_events_s;

    // latched ahb address phase
    typedef struct packed {
        logic valid;
        logic write;
        logic [13:0] addr;
    } fie_aphase_s;

endpackage : fie_pkg

// ==== fie_top.sv ====
// fiber interrupt enable/pending registers behind an ahb-lite slave
// assumes event inputs are one-cycle pulses synchronous to clk
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/100ps
module fie_top
    import fie_pkg::*;
(
    input wire logic clk, // 100 MHz core clock
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire fie_events_s events, // event pulses
    input wire fie_speed_e link_speed, // negotiated speed
    output logic irq, // level interrupt
    output logic mii_allowed, // legacy mac interface usable
    output logic sgmii_allowed // serial mac interface usable
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [FIE_NUM_EVENTS-1:0] enable_reg; // event enables
    logic [FIE_NUM_EVENTS-1:0] pending_reg; // sticky pending flags
    logic [3:0] mode_reg; // media and mac interface selection
    fie_aphase_s aphase_reg; // address phase held for data phase
    logic [FIE_NUM_EVENTS-1:0] event_vec; // events as a vector
    logic [FIE_NUM_EVENTS-1:0] clear_vec; // bits cleared by a read
    logic wr_enable; // data-phase write to enable
    logic wr_mode; // data-phase write to mode
    logic rd_pending; // data-phase read of pending
    fie_media_e media_mode;
    fie_mac_e mac_mode;

    assign event_vec = events;
    assign media_mode = fie_media_e'(mode_reg[FIE_MODE_MEDIA_LSB +: 2]);
    assign mac_mode = fie_mac_e'(mode_reg[FIE_MODE_MAC_LSB +: 2]);

    // zero wait states, every answer okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ------------------------------------------------------------
    // ahb address phase capture
    // ------------------------------------------------------------
    // only whole-word transfers write or clear the registers; other sizes still return read data
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            aphase_reg <= '0;
        end else if (hready) begin
            aphase_reg.valid <= hsel && (htrans == FIE_HTRANS_NONSEQ
                || htrans == FIE_HTRANS_SEQ) && (hsize == FIE_HSIZE_WORD);
            aphase_reg.write <= hwrite;
            aphase_reg.addr <= haddr[13:0];
        end
    end

    // address decode for the data phase
    always_comb begin
        wr_enable = 1'b0;
        wr_mode = 1'b0;
        rd_pending = 1'b0;
        if (!aphase_reg.valid) begin
            // idle: nothing decoded
        end else if (aphase_reg.addr == FIE_ENABLE_ADDR) begin
            wr_enable = aphase_reg.write;
        end else if (aphase_reg.addr == FIE_PENDING_ADDR) begin
            rd_pending = !aphase_reg.write;
        end else if (aphase_reg.addr == FIE_MODE_ADDR) begin
            wr_mode = aphase_reg.write;
        end
    end

    // ------------------------------------------------------------
    // enable register
    // ------------------------------------------------------------
    // all ten sources come out of reset enabled
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            enable_reg <= FIE_ENABLE_RESET[FIE_NUM_EVENTS-1:0]; // R17
        end else if (wr_enable) begin
            // bits 9..0 map one per source, upper bits dropped
            enable_reg <= hwdata[FIE_NUM_EVENTS-1:0]; // R1 R2 R3 R4 R5 R6 R7 R8 R9 R10
        end
    end

    // ------------------------------------------------------------
    // pending register, clear on read
    // ------------------------------------------------------------
    // the clear only hits bits the read actually returned
    assign clear_vec = rd_pending ? hrdata[FIE_NUM_EVENTS-1:0] : '0; // R11

    // pending latches regardless of enable, so software can poll
    genvar gi;
    generate
        for (gi = 0; gi < FIE_NUM_EVENTS; gi++) begin : g_pend
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    pending_reg[gi] <= FIE_PENDING_RESET[gi]; // R12
                end else if (event_vec[gi]) begin
                    // set beats a same-cycle read clear, no event lost
                    pending_reg[gi] <= 1'b1; // R13
                end else if (clear_vec[gi]) begin
                    pending_reg[gi] <= 1'b0; // R11
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // mode register and mac interface constraints
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_reg <= FIE_MODE_RESET;
        end else if (wr_mode) begin
            mode_reg <= hwdata[3:0];
        end
    end

    // legacy interface has no gigabit path; software keeps advert off
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mii_allowed <= 1'b0;
        end else begin
            mii_allowed <= (mac_mode == FIE_MAC_MII)
                && (link_speed == FIE_SPEED_10 || link_speed == FIE_SPEED_100); // R14 R15
        end
    end

    // serial pins are reused for fiber signals in those modes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sgmii_allowed <= 1'b0;
        end else begin
            sgmii_allowed <= (mac_mode == FIE_MAC_SGMII)
                && (media_mode != FIE_MEDIA_FIBER)
                && (media_mode != FIE_MEDIA_CONVERTER); // R16
        end
    end

    // ------------------------------------------------------------
    // interrupt output
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(pending_reg & enable_reg & ~clear_vec) | |(event_vec & enable_reg); // R18
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    // read mux registered in address phase so data is stable in data phase
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hrdata <= '0;
        end else if (hready) begin
            hrdata <= '0; // reserved and unmapped read zero, R18
            if (!(hsel && htrans[1] && !hwrite)) begin
                // no read: keep zero
            end else if (haddr[13:0] == FIE_ENABLE_ADDR) begin
                hrdata[FIE_NUM_EVENTS-1:0] <= enable_reg;
            end else if (haddr[13:0] == FIE_PENDING_ADDR) begin
                // include same-cycle events so they are returned and cleared
                hrdata[FIE_NUM_EVENTS-1:0] <= pending_reg | event_vec;
            end else if (haddr[13:0] == FIE_MODE_ADDR) begin
                hrdata[3:0] <= mode_reg;
            end
        end
    end

endmodule : fie_top

// ==== fie_top_sva.sv ====
// checker for the fiber interrupt block: bus, irq and mode outputs
// assumes it is bound to fie_top and sees only that module's ports
`timescale 1ns/100ps
module fie_top_sva
    import fie_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire fie_events_s events,
    input wire fie_speed_e link_speed,
    input wire logic irq,
    input wire logic mii_allowed,
    input wire logic sgmii_allowed
);
    // ------------------------------------------------------------
    // shadow of enable and mode, followed from word writes
    // ------------------------------------------------------------
    logic wr_v; // write address phase taken
    logic [13:0] wr_a; // its address
    logic [9:0] en_sh; // enable copy
    logic [3:0] mode_sh; // mode copy
    logic [9:0] ev_v; // events as a plain vector
    logic rd_now; // pending read address phase
    assign ev_v = events;
    assign rd_now = hsel && hready && htrans[1] && !hwrite && haddr[13:0] == FIE_PENDING_ADDR;
    // non-word writes are ignored by the slave, so the copy ignores them too
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_v <= 1'b0;
            wr_a <= 14'h0;
            en_sh <= FIE_ENABLE_RESET[9:0];
            mode_sh <= FIE_MODE_RESET;
        end else begin
            wr_v <= hsel && hready && htrans[1] && hwrite && hsize == FIE_HSIZE_WORD;
            wr_a <= haddr[13:0];
            if (wr_v && wr_a == FIE_ENABLE_ADDR) begin
                en_sh <= hwdata[9:0];
            end
            if (wr_v && wr_a == FIE_MODE_ADDR) begin
                mode_sh <= hwdata[3:0];
            end
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_bus; hreadyout && !hresp; endproperty
    a_bus: assert property (p_bus) else $error("bus not ready or not okay");
    property p_rsvd; hrdata[31:10] == 22'h0; endproperty
    a_rsvd: assert property (p_rsvd) else $error("upper read bits set");
    property p_irq_event; |(ev_v & en_sh) |=> irq; endproperty
    a_irq_event: assert property (p_irq_event) else $error("irq missing");
    property p_irq_mask; en_sh == 10'h0 |=> !irq; endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked irq");
    property p_ev_read;
        rd_now && |ev_v |=> (hrdata[9:0] & $past(ev_v)) == $past(ev_v);
    endproperty
    a_ev_read: assert property (p_ev_read) else $error("event lost in read");
    property p_mii_no; link_speed == FIE_SPEED_1000 |=> !mii_allowed; endproperty
    a_mii_no: assert property (p_mii_no) else $error("mii at gigabit");
    property p_mii_ok;
        mode_sh[3:2] == FIE_MAC_MII && link_speed inside {FIE_SPEED_10, FIE_SPEED_100}
            |=> mii_allowed;
    endproperty
    a_mii_ok: assert property (p_mii_ok) else $error("mii refused");
    property p_sgmii_no;
        mode_sh[1:0] inside {FIE_MEDIA_FIBER, FIE_MEDIA_CONVERTER} |=> !sgmii_allowed;
    endproperty
    a_sgmii_no: assert property (p_sgmii_no) else $error("sgmii in fiber");
    c_ev_read: cover property (rd_now && |ev_v);
    c_mii: cover property (mii_allowed);
    c_sgmii: cover property (sgmii_allowed);
endmodule : fie_top_sva
bind fie_top fie_top_sva u_sva (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .events(events),
    .link_speed(link_speed), .irq(irq), .mii_allowed(mii_allowed),
    .sgmii_allowed(sgmii_allowed));

// ==== fie_top_test.sv ====
// self-checking bench for the fiber interrupt enable/pending block
// assumes one 100 MHz clock and a zero-wait ahb-lite slave
`timescale 1ns/100ps
module fie_top_test
    import fie_pkg::*;
();
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = FIE_HSIZE_WORD;
    logic [31:0] hwdata = 32'h0;
    logic hready; // single slave: hready is hreadyout
    logic [31:0] hrdata;
    logic hreadyout, hresp, irq, mii_allowed, sgmii_allowed;
    fie_events_s events = '0;
    fie_speed_e link_speed = FIE_SPEED_10;
    int n_errors = 0;
    int cmp_count = 0;
    assign hready = hreadyout;
    always #5 clk = ~clk;
    fie_top dut (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .events(events), .link_speed(link_speed),
        .irq(irq), .mii_allowed(mii_allowed), .sgmii_allowed(sgmii_allowed));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask : chk
    // one single transfer; waits on hready, never on a fixed count
    task automatic bus(input logic wr, input logic [13:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {18'h0, a};
        htrans <= FIE_HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask : bus
    task automatic wr(input logic [13:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rd_chk(input string nm, input logic [13:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(nm, exp, q);
    endtask : rd_chk
    // let n edges land, then look
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    task automatic pulse(input logic [9:0] v);
        @(posedge clk);
        events <= v;
        @(posedge clk);
        events <= '0;
    endtask : pulse
    task automatic test_done;
        $display("checks %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        settle(1);
        chk("irq reset", 32'h0, {31'h0, irq});
        rd_chk("enable reset", FIE_ENABLE_ADDR, {16'h0, FIE_ENABLE_RESET});
        rd_chk("pending reset", FIE_PENDING_ADDR, 32'h0);
        wr(14'h3070, 32'hffff_ffff);
        rd_chk("unmapped", 14'h3070, 32'h0);
        wr(FIE_ENABLE_ADDR, 32'hffff_ffff);
        rd_chk("enable reserved", FIE_ENABLE_ADDR, 32'h3ff);
        // each enable bit masks only its own event; pending sets anyway
        for (int i = 0; i < FIE_NUM_EVENTS; i++) begin
            wr(FIE_ENABLE_ADDR, 32'h3ff & ~(32'h1 << i));
            pulse(10'h1 << i);
            settle(1);
            chk("irq masked", 32'h0, {31'h0, irq});
            wr(FIE_ENABLE_ADDR, 32'h3ff);
            settle(1);
            chk("irq unmasked", 32'h1, {31'h0, irq});
            rd_chk("pending bit", FIE_PENDING_ADDR, 32'h1 << i);
            rd_chk("pending cleared", FIE_PENDING_ADDR, 32'h0);
            settle(1);
            chk("irq cleared", 32'h0, {31'h0, irq});
        end
        // event landing with a pending read: returned by it, then cleared
        wr(FIE_ENABLE_ADDR, 32'h0);
        fork
            pulse(10'h200);
            rd_chk("pending same cycle", FIE_PENDING_ADDR, 32'h200);
        join
        settle(1);
        chk("irq all masked", 32'h0, {31'h0, irq});
        rd_chk("pending after race", FIE_PENDING_ADDR, 32'h0);
        wr(FIE_ENABLE_ADDR, 32'h3ff);
        chk("bus status", 32'h2, {30'h0, hreadyout, hresp});
        // every mode against speeds 10, 100 and 1000 and the interface limits
        for (int m = 0; m < 16; m++) begin
            for (int s = 0; s < 3; s++) begin
                link_speed <= fie_speed_e'(s);
                wr(FIE_MODE_ADDR, m);
                settle(1);
                chk("mii", {31'h0, m[3:2] == 2'h2 && s < 2}, {31'h0, mii_allowed});
                chk("sgmii", {31'h0, m[3:2] == 2'h1 && !(m[1:0] inside {2'h1, 2'h2})},
                    {31'h0, sgmii_allowed});
            end
        end
        test_done();
    end
    // hang guard, far beyond the few hundred cycles the sequence needs
    initial begin
        #200000;
        n_errors++;
        test_done();
    end
endmodule : fie_top_test
